// [rtl/gyro_status_ctrl.sv]
`timescale 1ns/1ps
`include "gyro_status_regs.svh"
module gyro_status_ctrl #(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A // arbitrary value
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic soft_reset_i,
    input wire logic boot_complete_i,
    input wire gyro_status_pkg::op_mode_e op_mode_i,
    input wire logic sample_tick_i,
    input wire logic [5:0] sample_count_i,
    input wire logic [5:0] watermark_level_i,
    input wire logic threshold_event_active_i,
    input wire logic queue_irq_enable_i,
    input wire logic threshold_irq_enable_i,
    input wire logic sample_ready_irq_enable_i,
    input wire logic [2:0] sample_ready_flags_i,
    input wire logic [2:0] axis_msb_read_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic [1:0] lowpass_bandwidth_choice_o,
    output logic three_wire_serial_select_o,
    output logic [1:0] highpass_cutoff_o,
    output logic highpass_enable_o,
    output logic [1:0] full_scale_choice_o,
    output logic filter_reinit_o,
    output logic queue_overflow_flag_o,
    output logic queue_watermark_flag_o,
    output logic [7:0] irq_source_o
);
    import gyro_status_pkg::*;
    // ****************************************
    // state
    // ****************************************
    op_mode_e mode_ff;
    boot_state_e boot_ff;
    reg_byte_t cfg_ff;
    logic to_active;
    logic fifo_event;
    logic [4:0] fifo_event_age;
    logic queue_src_ff;
    logic thr_src_ff;
    logic ready_src_ff;
    logic [2:0] msb_seen_ff;
    logic [2:0] nxt_msb_seen;
    logic [7:0] nxt_rdata;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_ff <= MODE_STANDBY;
        end else begin
            mode_ff <= op_mode_i;
        end
    end
    assign to_active = (op_mode_i == MODE_ACTIVE) &&
        (mode_ff != MODE_ACTIVE);
    // ****************************************
    // fifo flags and event
    // ****************************************
    queue_flag_gen u_flags (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .sample_count_i(sample_count_i),
        .watermark_level_i(watermark_level_i),
        .sample_tick_i(sample_tick_i),
        .queue_overflow_flag_o(queue_overflow_flag_o),
        .queue_watermark_flag_o(queue_watermark_flag_o)
    );
    fifo_event_tracker u_event (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .mode_to_active_i(to_active),
        .sample_tick_i(sample_tick_i),
        .queue_overflow_flag_i(queue_overflow_flag_o),
        .queue_watermark_flag_i(queue_watermark_flag_o),
        .fifo_event_o(fifo_event),
        .fifo_event_age_o(fifo_event_age)
    );
    // ****************************************
    // boot done
    // ****************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_ff <= BOOT_RUN;
        end else if (soft_reset_i) begin
            boot_ff <= BOOT_RUN;
        end else if (boot_complete_i) begin
            boot_ff <= BOOT_DONE;
        end
    end
    // ****************************************
    // interrupt sources
    // ****************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            queue_src_ff <= 1'b0;
        end else if (!fifo_event) begin
            queue_src_ff <= 1'b0;
        end else if (queue_irq_enable_i) begin
            queue_src_ff <= 1'b1;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thr_src_ff <= 1'b0;
        end else if (!threshold_event_active_i) begin
            thr_src_ff <= 1'b0;
        end else if (threshold_irq_enable_i) begin
            thr_src_ff <= 1'b1;
        end
    end
    // msb reads collected since the source set; all three release it
    always_comb begin
        nxt_msb_seen = msb_seen_ff | axis_msb_read_i;
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            msb_seen_ff <= 3'h0;
        end else if (!ready_src_ff || nxt_msb_seen == 3'h7) begin
            msb_seen_ff <= 3'h0;
        end else begin
            msb_seen_ff <= nxt_msb_seen;
        end
    end
    // release wins over a new ready flag in the same cycle; set needs the source clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_src_ff <= 1'b0;
        end else if (sample_ready_irq_enable_i &&
                     |sample_ready_flags_i && !ready_src_ff) begin
            ready_src_ff <= 1'b1;
        end else if (ready_src_ff && nxt_msb_seen == 3'h7) begin
            ready_src_ff <= 1'b0;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_source_o <= 8'h00;
        end else begin
            irq_source_o <= {4'h0, boot_ff == BOOT_DONE, queue_src_ff,
                thr_src_ff, ready_src_ff};
        end
    end
    // ****************************************
    // main configuration
    // ****************************************
    // writes in active mode are accepted; keeping out of active is the host's
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_ff <= `MAIN_CFG_RESET;
        end else if (reg_wr_i && reg_addr_i == `OFS_MAIN_CONFIGURATION) begin
            cfg_ff <= reg_wdata_i;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lowpass_bandwidth_choice_o <= 2'h0;
            three_wire_serial_select_o <= 1'b0;
            highpass_cutoff_o <= 2'h0;
            highpass_enable_o <= 1'b0;
            full_scale_choice_o <= 2'h0;
        end else begin
            lowpass_bandwidth_choice_o <= cfg_ff[7:6];
            three_wire_serial_select_o <= cfg_ff[`CFG_THREE_WIRE_SERIAL_SELECT_BIT];
            highpass_cutoff_o <= cfg_ff[4:3];
            highpass_enable_o <= cfg_ff[`CFG_HPF_BIT];
            full_scale_choice_o <= cfg_ff[1:0];
        end
    end
    // filter restarts on any mode change
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            filter_reinit_o <= 1'b0;
        end else begin
            filter_reinit_o <= (op_mode_i != mode_ff);
        end
    end
    // ****************************************
    // read port: reads have no side effects
    // ****************************************
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (reg_addr_i)
            `OFS_FIFO_EVENT_STATUS: nxt_rdata = {2'h0, fifo_event,
                fifo_event_age};
            `OFS_IRQ_SOURCE_FLAGS: nxt_rdata = {4'h0, boot_ff == BOOT_DONE,
                queue_src_ff, thr_src_ff, ready_src_ff};
            `OFS_DEVICE_IDENTITY: nxt_rdata = IDENTITY_CODE;
            `OFS_MAIN_CONFIGURATION: nxt_rdata = cfg_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end
    end
endmodule

// [common/gyro_status_regs.svh]
// Function
// - fifo event bit is the or of overflow and watermark flags
// - event bit stays set until both flags have cleared
// - five-bit age field counts samples since the event bit set
// - age field returns to zero only when the event bit clears
// - event register clears on standby or ready to active change
// - reading the source register clears nothing
// - boot done bit sets when boot completes, then stays one
// - boot done bit clears on hard, soft or power-on reset
// - queue source bit follows event bit gated by fifo enable
// - threshold source bit follows event-active flag gated by enable
// - sample ready source sets on any axis ready flag when enabled
// - sample ready source clears after host reads x, y, z msbs
// - identity register is read-only with a fixed code
// - main configuration fields laid out as documented, reset zero
// - three-wire select picks four-wire at zero, three-wire at one
// - highpass enable routes filtered data; filter reinit on mode changes only, not on config writes
// - overflow flag sets on sample at 32 stored, clears below 32
// - watermark flag tracks count at or above a nonzero watermark level
`ifndef GYRO_STATUS_REGS_SVH
`define GYRO_STATUS_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_FIFO_EVENT_STATUS 8'h0A
`define OFS_IRQ_SOURCE_FLAGS 8'h0B
`define OFS_DEVICE_IDENTITY 8'h0C
`define OFS_MAIN_CONFIGURATION 8'h0D
// ****************************************
// field positions and reset values
// ****************************************
`define FEV_EVENT_BIT 5
`define ISRC_BOOT_BIT 3
`define ISRC_QUEUE_BIT 2
`define ISRC_THR_BIT 1
`define ISRC_READY_BIT 0
`define CFG_THREE_WIRE_SERIAL_SELECT_BIT 5
`define CFG_HPF_BIT 2
`define MAIN_CFG_RESET 8'h00
`define QUEUE_DEPTH 6'h20
`endif

// [common/gyro_status_pkg.sv]
package gyro_status_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [5:0] sample_count_t;
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_READY = 2'b01,
        MODE_ACTIVE = 2'b10
    } op_mode_e;
    typedef enum logic [1:0] {
        BOOT_RUN = 2'b00,
        BOOT_DONE = 2'b01
    } boot_state_e;
endpackage

// [rtl/fifo_event_tracker.sv]
`timescale 1ns/1ps
`include "gyro_status_regs.svh"
module fifo_event_tracker (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic mode_to_active_i,
    input wire logic sample_tick_i,
    input wire logic queue_overflow_flag_i,
    input wire logic queue_watermark_flag_i,
    output logic fifo_event_o,
    output logic [4:0] fifo_event_age_o
);
    logic event_now;
    assign event_now = queue_overflow_flag_i | queue_watermark_flag_i;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fifo_event_o <= 1'b0;
        end else if (mode_to_active_i) begin
            fifo_event_o <= 1'b0;
        end else begin
            fifo_event_o <= event_now;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fifo_event_age_o <= 5'h00;
        end else if (mode_to_active_i || !event_now) begin
            fifo_event_age_o <= 5'h00;
        end else if (fifo_event_o && sample_tick_i &&
                     fifo_event_age_o != 5'h1F) begin
            // saturates rather than wrapping so an old event never looks new
            fifo_event_age_o <= fifo_event_age_o + 5'h01;
        end
    end
endmodule

// [rtl/queue_flag_gen.sv]
`timescale 1ns/1ps
`include "gyro_status_regs.svh"
module queue_flag_gen (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [5:0] sample_count_i,
    input wire logic [5:0] watermark_level_i,
    input wire logic sample_tick_i,
    output logic queue_overflow_flag_o,
    output logic queue_watermark_flag_o
);
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            queue_overflow_flag_o <= 1'b0;
        end else if (sample_tick_i && sample_count_i == `QUEUE_DEPTH) begin
            queue_overflow_flag_o <= 1'b1;
        end else if (sample_count_i < `QUEUE_DEPTH) begin
            queue_overflow_flag_o <= 1'b0;
        end
    end
    // a zero level suppresses the flag
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            queue_watermark_flag_o <= 1'b0;
        end else begin
            queue_watermark_flag_o <= (watermark_level_i != 6'h00) &&
                (sample_count_i >= watermark_level_i);
        end
    end
endmodule

// [test/gyro_status_sva.sv]
`timescale 1ns/1ps
module gyro_status_sva import gyro_status_pkg::*; #(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic soft_reset_i,
    input wire logic boot_complete_i,
    input wire op_mode_e op_mode_i,
    input wire logic sample_tick_i,
    input wire logic [5:0] sample_count_i,
    input wire logic [5:0] watermark_level_i,
    input wire logic threshold_event_active_i,
    input wire logic threshold_irq_enable_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [1:0] lowpass_bandwidth_choice_o,
    input wire logic three_wire_serial_select_o,
    input wire logic [1:0] highpass_cutoff_o,
    input wire logic highpass_enable_o,
    input wire logic [1:0] full_scale_choice_o,
    input wire logic filter_reinit_o,
    input wire logic queue_overflow_flag_o,
    input wire logic queue_watermark_flag_o,
    input wire logic [7:0] irq_source_o
);
    import gyro_status_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // ****************************************
    // status flags and register answers
    // ****************************************
    ovf_set_a: assert property (
        sample_tick_i && sample_count_i == 6'h20 |=> queue_overflow_flag_o)
        else $error("overflow not set");
    ovf_clear_a: assert property (
        sample_count_i < 6'h20 |=> !queue_overflow_flag_o)
        else $error("overflow not cleared");
    wmk_track_a: assert property (
        1 |=> queue_watermark_flag_o ==
            $past(watermark_level_i != 6'h00 &&
            sample_count_i >= watermark_level_i))
        else $error("watermark wrong");
    boot_set_a: assert property (
        boot_complete_i && !soft_reset_i ##1 !soft_reset_i
            |-> ##[1:2] irq_source_o[3])
        else $error("boot done not set");
    boot_hold_a: assert property (
        irq_source_o[3] && !$past(soft_reset_i) |=> irq_source_o[3])
        else $error("boot done dropped");
    boot_clear_a: assert property (
        soft_reset_i && !boot_complete_i ##1 !boot_complete_i
            |=> !irq_source_o[3])
        else $error("boot done kept");
    thr_source_a: assert property (
        threshold_event_active_i && threshold_irq_enable_i
            |=> ##1 irq_source_o[1])
        else $error("threshold source low");
    ident_read_a: assert property (
        reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o == IDENTITY_CODE)
        else $error("identity wrong");
    cfg_out_a: assert property (
        reg_wr_i && reg_addr_i == 8'h0D |=> ##1
            {lowpass_bandwidth_choice_o, three_wire_serial_select_o,
            highpass_cutoff_o, highpass_enable_o, full_scale_choice_o} ==
            $past(reg_wdata_i, 2))
        else $error("config fields wrong");
    filter_init_a: assert property (
        op_mode_i != $past(op_mode_i) |=> filter_reinit_o)
        else $error("no filter reinit");
endmodule
bind gyro_status_ctrl gyro_status_sva #(.IDENTITY_CODE(IDENTITY_CODE))
    gyro_status_sva_inst (.*);

// [test/host_model.sv]
`timescale 1ns/1ps
module host_model import gyro_status_pkg::*; (
    input wire logic core_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic [2:0] axis_msb_read_o
);
    import gyro_status_pkg::*;
    // ****************************************
    // register strobes, one request per call
    // ****************************************
    initial begin
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 18'h00000;
        axis_msb_read_o = 3'h0;
    end
    // config writes are only issued while the bench keeps standby
    task wr(input reg_byte_t a, input reg_byte_t v);
        @(posedge core_clk_i) #1;
        {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, v};
        @(posedge core_clk_i) #1;
        reg_wr_o = 1'b0;
    endtask
    task rd(input reg_byte_t a, output reg_byte_t q);
        @(posedge core_clk_i) #1;
        {reg_rd_o, reg_addr_o} = {1'b1, a};
        @(posedge core_clk_i) #1;
        q = reg_rdata_i;
        reg_rd_o = 1'b0;
    endtask
    // upper sample bytes are what release the ready source
    task msb(input int i);
        @(posedge core_clk_i) #1;
        axis_msb_read_o[i] = 1'b1;
        @(posedge core_clk_i) #1;
        axis_msb_read_o[i] = 1'b0;
    endtask
endmodule

// [test/gyro_status_ctrl_tb_top.sv]
`timescale 1ns/1ps
module gyro_status_ctrl_tb_top;
    import gyro_status_pkg::*;
    logic core_clk_i = 0, nrst_i = 0, soft_reset_i = 0, boot_complete_i = 0;
    op_mode_e op_mode_i = MODE_STANDBY;
    logic sample_tick_i = 0, threshold_event_active_i = 0;
    logic queue_irq_enable_i = 0, threshold_irq_enable_i = 0;
    logic sample_ready_irq_enable_i = 0;
    logic [2:0] sample_ready_flags_i = 3'h0, axis_msb_read_i;
    logic [5:0] sample_count_i = 6'h00, watermark_level_i = 6'h08;
    logic reg_wr_i, reg_rd_i, filter_reinit_o, three_wire_serial_select_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, irq_source_o;
    logic [1:0] lowpass_bandwidth_choice_o, highpass_cutoff_o;
    logic [1:0] full_scale_choice_o;
    logic highpass_enable_o, queue_overflow_flag_o, queue_watermark_flag_o;
    reg_byte_t d;
    reg_byte_t d_tab[4] = '{8'h24, 8'hC3, 8'h18, 8'h00};
    op_mode_e m_tab[2] = '{MODE_STANDBY, MODE_READY};
    int num_errors = 0, num_checks = 0;
    always #4 core_clk_i = ~core_clk_i;
    gyro_status_ctrl gyro_status_ctrl_inst (.*);
    host_model host_model_inst (.core_clk_i(core_clk_i),
        .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .axis_msb_read_o(axis_msb_read_i));
    // ****************************************
    // shared helpers
    // ****************************************
    task chk(string n, reg_byte_t s, reg_byte_t e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // leaves time one step past a rising edge, where inputs may change
    task cyc(int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task tick(int n);
        repeat (n) begin
            cyc(1);
            sample_tick_i = 1;
            cyc(1);
            sample_tick_i = 0;
        end
    endtask
    task rdc(reg_byte_t a, reg_byte_t e, string n);
        host_model_inst.rd(a, d);
        chk(n, d, e);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        rdc(8'h0A, 8'h00, "event_rst");
        rdc(8'h0B, 8'h00, "source_rst");
        rdc(8'h0C, 8'h5A, "ident");
        rdc(8'h0D, 8'h00, "config_rst");
        rdc(8'h20, 8'h00, "unmapped");
        host_model_inst.wr(8'h0C, 8'hFF);
        rdc(8'h0C, 8'h5A, "ident_ro");
        foreach (d_tab[i]) begin
            host_model_inst.wr(8'h0D, d_tab[i]);
            rdc(8'h0D, d_tab[i], "config_rd");
            chk("cfg_out", {lowpass_bandwidth_choice_o,
                three_wire_serial_select_o, highpass_cutoff_o,
                highpass_enable_o, full_scale_choice_o}, d_tab[i]);
        end
        $display("test regs done");
    endtask
    task t_event;
        queue_irq_enable_i = 1;
        sample_count_i = 6'h0A;
        cyc(4);
        chk("wmk", {7'h00, queue_watermark_flag_o}, 8'h01);
        tick(3);
        rdc(8'h0A, 8'h23, "age3");
        chk("qsrc", irq_source_o, 8'h04);
        sample_count_i = 6'h20;
        tick(1);
        chk("ovf", {7'h00, queue_overflow_flag_o}, 8'h01);
        sample_count_i = 6'h1F;
        cyc(2);
        chk("ovf_clr", {7'h00, queue_overflow_flag_o}, 8'h00);
        rdc(8'h0A, 8'h24, "one_flag");
        sample_count_i = 6'h04;
        cyc(5);
        rdc(8'h0A, 8'h00, "ev_clr");
        chk("qsrc_clr", irq_source_o, 8'h00);
        sample_count_i = 6'h0A;
        cyc(4);
        foreach (m_tab[i]) begin
            op_mode_i = m_tab[i];
            tick(5);
            op_mode_i = MODE_ACTIVE;
            cyc(4);
            rdc(8'h0A, 8'h20, "mode_clr");
        end
        op_mode_i = MODE_STANDBY;
        sample_count_i = 6'h00;
        cyc(5);
        $display("test event done");
    endtask
    task t_src;
        threshold_event_active_i = 1;
        cyc(3);
        chk("thr_off", irq_source_o, 8'h00);
        threshold_irq_enable_i = 1;
        cyc(3);
        chk("thr_on", irq_source_o, 8'h02);
        rdc(8'h0B, 8'h02, "rd1");
        rdc(8'h0B, 8'h02, "rd2");
        threshold_event_active_i = 0;
        cyc(3);
        chk("thr_clr", irq_source_o, 8'h00);
        sample_ready_irq_enable_i = 1;
        sample_ready_flags_i = 3'h2;
        cyc(1);
        sample_ready_flags_i = 3'h0;
        cyc(3);
        chk("rdy", irq_source_o, 8'h01);
        host_model_inst.msb(0);
        host_model_inst.msb(1);
        cyc(3);
        chk("rdy_two", irq_source_o, 8'h01);
        host_model_inst.msb(2);
        cyc(3);
        chk("rdy_clr", irq_source_o, 8'h00);
        boot_complete_i = 1;
        cyc(3);
        boot_complete_i = 0;
        cyc(3);
        chk("boot", irq_source_o, 8'h08);
        soft_reset_i = 1;
        cyc(1);
        soft_reset_i = 0;
        cyc(3);
        chk("boot_soft", irq_source_o, 8'h00);
        boot_complete_i = 1;
        cyc(3);
        nrst_i = 0;
        boot_complete_i = 0;
        cyc(1);
        chk("boot_por", irq_source_o, 8'h00);
        nrst_i = 1;
        $display("test sources done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        cyc(3);
        nrst_i = 1;
        t_regs;
        t_event;
        t_src;
        cyc(3);
        stop_test;
    end
    // the whole run is under 150 cycles; this is far past it
    initial begin
        #100000;
        num_errors++;
        stop_test;
    end
endmodule
